//--- rtl/bds_pkg.sv
/*
  Shared constants for the bench monitor data source: register map, field positions,
  reset values, multiplex address ranges and the simulated unit patterns.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package bds_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_ADDR = 8'h04;
  localparam logic [AXI_AW-1:0] REG_DATA = 8'h08;
  localparam logic [AXI_AW-1:0] REG_PSEL = 8'h0C;
  localparam logic [AXI_AW-1:0] REG_STAT = 8'h10;
  localparam logic [AXI_AW-1:0] REG_CMD = 8'h14;
  localparam logic [3:0] STRB_ALL = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ANY_BIT = 0;
  localparam int CTRL_CLR_ADDR_BIT = 1;
  localparam int CTRL_CLR_DATA_BIT = 2;
  localparam int PSEL_UNIT_LSB = 0;
  localparam int PSEL_PORT_LSB = 2;
  localparam int PSEL_OVR_BIT = 4;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_PEND_BIT = 9;
  // ----------------------------------------------------------------------
  // Widths, addresses and reset values
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 21;
  localparam int WORD_W = 24;
  localparam int MUX_W = 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h18;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [MUX_W-1:0] MUX_DIG_BASE = 8'h80;
  localparam logic [1:0] MUX_DIG_TOP = 2'h2;
  localparam logic [MUX_W-1:0] MUX_SERIAL = 8'h82;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h3F;
  localparam logic [DATA_W-1:0] DATA_RESET = 21'h1FFFFF;
  localparam logic [WORD_W-1:0] PAT_UNIT0 = 24'h000000;
  localparam logic [WORD_W-1:0] PAT_UNIT1 = 24'h555555;
  localparam logic [WORD_W-1:0] PAT_UNIT2 = 24'h333333;
  localparam logic [WORD_W-1:0] PAT_UNIT3 = 24'h777777;
endpackage

//--- rtl/bds_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides; width and depth are parameters.
  Assumes one clock and an asynchronous active-low reset; depth is at least two.
*/
`timescale 1ns/1ns
module bds_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_STEP = CW'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic in_ready;
    logic out_valid;
  } bds_fifo_state_t;

  bds_fifo_state_t st_reg;
  bds_fifo_state_t st_next;
  logic push;
  logic pop;

  assign push = in_valid_in && st_reg.in_ready;
  assign pop = out_ready_in && st_reg.out_valid;
  assign in_ready_out = st_reg.in_ready;
  assign out_valid_out = st_reg.out_valid;
  assign out_data_out = st_reg.mem[st_reg.rd];

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wr] = in_data_in;
      st_next.wr = (st_reg.wr == PTR_LAST) ? '0 : st_reg.wr + PW'(1);
    end
    if (pop)
    begin
      st_next.rd = (st_reg.rd == PTR_LAST) ? '0 : st_reg.rd + PW'(1);
    end
    if (push && !pop)
    begin
      st_next.cnt = st_reg.cnt + CNT_STEP;
    end
    else if (pop && !push)
    begin
      st_next.cnt = st_reg.cnt - CNT_STEP;
    end
    st_next.in_ready = (st_next.cnt != CNT_FULL);
    st_next.out_valid = (st_next.cnt != '0);
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_reg <= '{in_ready: 1'b1, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule

//--- rtl/bds_bench_data_source.sv
/*
  Bench data source: forces a held binary monitor word into the local field interface
  unit, and answers antenna-side buffer requests as the port selector.
  Assumes an AXI4-Lite master on clk_in; all field pins are asynchronous to clk_in and
  the unit clock is far slower than clk_in.
*/
`timescale 1ns/1ns
// Functional notes
// - Forced binary monitor data is fed to the local unit instead of subsystem data.
// - Follows the unit's mux-state, command, clock and strobe lines; drives its data line.
// - Stored address is '00..'77; the real digital address adds '200.
// - Stored data spans '0000000..'7777777 and holds until changed.
// - Clear sets address to '77 and data to '7777777, each separately.
// - Select mode serves one stored address; any mode serves every digital address.
// - Address and data storage are independent of each other.
// - Port selector reads the unit switch and simulates every other unit.
// - Simulated words: unit 0..3 give 000000, 555555, 333333, 777777.
// - Hardwired unit address and buffer port can be changed by software.
// - Address '202 of the real unit always returns the antenna serial number.
// - Serial number comes from the two antenna identity switch digits.
// - A word starts only when the strobe rises while the unit's mux state matches the served address.
// - Digital points are '200..'277, each one 24-bit word.
module bds_bench_data_source #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // AXI4-Lite register bus
  input wire logic [bds_pkg::AXI_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [bds_pkg::AXI_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Field interface unit
  input wire logic [bds_pkg::MUX_W-1:0] sequence_mux_state_in,
  input wire logic [bds_pkg::WORD_W-1:0] fiu_cmd_data_in,
  input wire logic fiu_cmd_strobe_in,
  input wire logic fiu_bin_clk_in,
  input wire logic fiu_bin_strobe_in,
  output logic fiu_bin_data_out,
  output logic fiu_bin_active_out,
  // Port selector, antenna side buffer
  input wire logic [1:0] unit_address_switch_in,
  input wire logic [7:0] ant_id_switch_in,
  input wire logic asb_req_in,
  input wire logic [1:0] asb_unit_in,
  input wire logic [bds_pkg::MUX_W-1:0] asb_mux_in,
  output logic [bds_pkg::WORD_W-1:0] asb_word_out,
  output logic asb_real_out,
  output logic [1:0] asb_port_out,
  output logic asb_ack_out
);
  import bds_pkg::*;

  localparam int PAD_W = WORD_W - DATA_W;

  typedef struct packed {
    logic [MUX_W-1:0] mux_s1;
    logic [MUX_W-1:0] mux_s2;
    logic [2:0] bclk_s;
    logic [2:0] bstb_s;
    logic [2:0] cstb_s;
    logic [2:0] areq_s;
    logic [WORD_W-1:0] cmd_s1;
    logic [WORD_W-1:0] cmd_s2;
    logic [WORD_W-1:0] cmd_last;
    logic [1:0] unit_s1;
    logic [1:0] unit_s2;
    logic [1:0] sw_s1;
    logic [1:0] sw_s2;
    logic [MUX_W-1:0] amux_s1;
    logic [MUX_W-1:0] amux_s2;
    logic [7:0] ant_s1;
    logic [7:0] ant_s2;
    logic any_mode;
    logic ovr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0] hw_unit;
    logic [1:0] port;
    logic busy;
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] cnt;
    logic bin_data;
    logic [WORD_W-1:0] asb_word;
    logic asb_real;
    logic [1:0] asb_port;
    logic asb_ack;
    logic aw_done;
    logic w_done;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bds_state_t;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_DATA) ||
              (a == REG_PSEL) || (a == REG_STAT) || (a == REG_CMD);
  endfunction

  function automatic logic is_digital(input logic [MUX_W-1:0] m);
    is_digital = (m[MUX_W-1:MUX_W-2] == MUX_DIG_TOP);
  endfunction

  function automatic logic [WORD_W-1:0] unit_pattern(input logic [1:0] u);
    case (u)
      2'h0: unit_pattern = PAT_UNIT0;
      2'h1: unit_pattern = PAT_UNIT1;
      2'h2: unit_pattern = PAT_UNIT2;
      default: unit_pattern = PAT_UNIT3;
    endcase
  endfunction

  bds_state_t st_reg;
  bds_state_t st_next;
  logic bclk_rise;
  logic bstb_rise;
  logic cstb_rise;
  logic areq_rise;
  logic match;
  logic load_go;
  logic [WORD_W-1:0] load_word;
  logic [1:0] hw_now;
  logic wr_go;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------------
  // Edge detection and serving decision
  // ----------------------------------------------------------------------
  assign bclk_rise = st_reg.bclk_s[1] && !st_reg.bclk_s[2];
  assign bstb_rise = st_reg.bstb_s[1] && !st_reg.bstb_s[2];
  assign cstb_rise = st_reg.cstb_s[1] && !st_reg.cstb_s[2];
  assign areq_rise = st_reg.areq_s[1] && !st_reg.areq_s[2];
  // Select mode serves only '200 plus the stored address; any mode serves every digital one.
  assign match = st_reg.any_mode ? is_digital(st_reg.mux_s2) :
                 (st_reg.mux_s2 == (MUX_DIG_BASE | {2'h0, st_reg.addr}));
  assign load_go = !st_reg.busy && bstb_rise && match;
  assign load_word = {{PAD_W{1'b0}}, st_reg.data};
  assign hw_now = st_reg.ovr ? st_reg.hw_unit : st_reg.sw_s2;

  // A DATA write waits for FIFO room, so a burst of writes stalls the bus, not the data.
  assign wr_go = st_reg.aw_done && st_reg.w_done && !st_reg.bvalid &&
                 ((st_reg.aw_addr != REG_DATA) || fifo_in_ready);
  assign fifo_push = wr_go && (st_reg.aw_addr == REG_DATA) && (st_reg.w_strb == STRB_ALL);

  bds_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) bds_fifo_inst (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(fifo_push),
    .in_data_in(st_reg.w_data[DATA_W-1:0]),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(!st_reg.busy)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.mux_s1 = sequence_mux_state_in;
    st_next.mux_s2 = st_reg.mux_s1;
    st_next.bclk_s = {st_reg.bclk_s[1:0], fiu_bin_clk_in};
    st_next.bstb_s = {st_reg.bstb_s[1:0], fiu_bin_strobe_in};
    st_next.cstb_s = {st_reg.cstb_s[1:0], fiu_cmd_strobe_in};
    st_next.areq_s = {st_reg.areq_s[1:0], asb_req_in};
    st_next.cmd_s1 = fiu_cmd_data_in;
    st_next.cmd_s2 = st_reg.cmd_s1;
    st_next.unit_s1 = asb_unit_in;
    st_next.unit_s2 = st_reg.unit_s1;
    st_next.sw_s1 = unit_address_switch_in;
    st_next.sw_s2 = st_reg.sw_s1;
    st_next.amux_s1 = asb_mux_in;
    st_next.amux_s2 = st_reg.amux_s1;
    st_next.ant_s1 = ant_id_switch_in;
    st_next.ant_s2 = st_reg.ant_s1;
    st_next.asb_ack = 1'b0;

    if (cstb_rise)
    begin
      st_next.cmd_last = st_reg.cmd_s2;
    end

    // New data is taken only between words, so a word never mixes two values.
    if (!st_reg.busy)
    begin
      if (fifo_out_valid)
      begin
        st_next.data = fifo_out_data;
      end
      if (load_go)
      begin
        st_next.busy = 1'b1;
        st_next.shift = load_word;
        st_next.bin_data = load_word[WORD_W-1];
        st_next.cnt = WORD_BITS;
      end
    end
    else if (!st_reg.bstb_s[1])
    begin
      // Strobe dropped early: abandon the word rather than shift into the next state.
      st_next.busy = 1'b0;
    end
    else if (bclk_rise)
    begin
      st_next.shift = {st_reg.shift[WORD_W-2:0], 1'b0};
      st_next.bin_data = st_reg.shift[WORD_W-2];
      st_next.cnt = st_reg.cnt - CNT_ONE;
      if (st_reg.cnt == CNT_ONE)
      begin
        st_next.busy = 1'b0;
      end
    end

    // Port selector answer.
    if (areq_rise)
    begin
      st_next.asb_ack = 1'b1;
      st_next.asb_port = st_reg.port;
      st_next.asb_real = (st_reg.unit_s2 == hw_now);
      if (st_reg.unit_s2 != hw_now)
      begin
        st_next.asb_word = unit_pattern(st_reg.unit_s2);
      end
      else if (st_reg.amux_s2 == MUX_SERIAL)
      begin
        st_next.asb_word = {3{st_reg.ant_s2}};
      end
      else
      begin
        st_next.asb_word = '0;
      end
    end

    // AXI4-Lite write channel.
    if (s_axi_awvalid_in && st_reg.awready)
    begin
      st_next.aw_done = 1'b1;
      st_next.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st_reg.wready)
    begin
      st_next.w_done = 1'b1;
      st_next.w_data = s_axi_wdata_in;
      st_next.w_strb = s_axi_wstrb_in;
    end
    if (st_reg.bvalid && s_axi_bready_in)
    begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      st_next.aw_done = 1'b0;
      st_next.w_done = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = reg_hit(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_reg.w_strb == STRB_ALL)
      begin
        case (st_reg.aw_addr)
          REG_CTRL:
          begin
            st_next.any_mode = st_reg.w_data[CTRL_ANY_BIT];
            if (st_reg.w_data[CTRL_CLR_ADDR_BIT])
            begin
              st_next.addr = ADDR_RESET;
            end
            if (st_reg.w_data[CTRL_CLR_DATA_BIT])
            begin
              st_next.data = DATA_RESET;
            end
          end
          REG_ADDR: st_next.addr = st_reg.w_data[ADDR_W-1:0];
          REG_PSEL:
          begin
            st_next.hw_unit = st_reg.w_data[PSEL_UNIT_LSB+:2];
            st_next.port = st_reg.w_data[PSEL_PORT_LSB+:2];
            st_next.ovr = st_reg.w_data[PSEL_OVR_BIT];
          end
          default: ;
        endcase
      end
    end
    st_next.awready = !st_next.aw_done && !st_next.bvalid;
    st_next.wready = !st_next.w_done && !st_next.bvalid;

    // AXI4-Lite read channel.
    if (st_reg.rvalid && s_axi_rready_in)
    begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = reg_hit(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
      st_next.rdata = '0;
      case (s_axi_araddr_in)
        REG_CTRL: st_next.rdata[CTRL_ANY_BIT] = st_reg.any_mode;
        REG_ADDR: st_next.rdata[ADDR_W-1:0] = st_reg.addr;
        REG_DATA: st_next.rdata[DATA_W-1:0] = st_reg.data;
        REG_PSEL:
        begin
          st_next.rdata[PSEL_UNIT_LSB+:2] = st_reg.hw_unit;
          st_next.rdata[PSEL_PORT_LSB+:2] = st_reg.port;
          st_next.rdata[PSEL_OVR_BIT] = st_reg.ovr;
        end
        REG_STAT:
        begin
          st_next.rdata[MUX_W-1:0] = st_reg.mux_s2;
          st_next.rdata[STAT_BUSY_BIT] = st_reg.busy;
          st_next.rdata[STAT_PEND_BIT] = fifo_out_valid;
        end
        REG_CMD: st_next.rdata[WORD_W-1:0] = st_reg.cmd_last;
        default: ;
      endcase
    end
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_reg <= '{addr: ADDR_RESET, data: DATA_RESET, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready_out = st_reg.awready;
  assign s_axi_wready_out = st_reg.wready;
  assign s_axi_bresp_out = st_reg.bresp;
  assign s_axi_bvalid_out = st_reg.bvalid;
  assign s_axi_arready_out = st_reg.arready;
  assign s_axi_rdata_out = st_reg.rdata;
  assign s_axi_rresp_out = st_reg.rresp;
  assign s_axi_rvalid_out = st_reg.rvalid;
  assign fiu_bin_data_out = st_reg.bin_data;
  assign fiu_bin_active_out = st_reg.busy;
  assign asb_word_out = st_reg.asb_word;
  assign asb_real_out = st_reg.asb_real;
  assign asb_port_out = st_reg.asb_port;
  assign asb_ack_out = st_reg.asb_ack;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence seq_load;
    load_go;
  endsequence

  sequence seq_last_bit;
    st_reg.busy && st_reg.bstb_s[1] && bclk_rise && (st_reg.cnt == CNT_ONE);
  endsequence

  AST_LOAD_ON_MATCH: assert property (seq_load |=> st_reg.busy && st_reg.cnt == WORD_BITS)
    else $error("word not loaded on matching strobe");
  AST_NO_LOAD_ELSE: assert property (!st_reg.busy && !load_go |=> !st_reg.busy)
    else $error("shift started without a matching mux state");
  AST_MSB_FIRST: assert property (seq_load |=> ((PAD_W == 0) ? fiu_bin_data_out == $past(st_reg.data[DATA_W-1]) : !fiu_bin_data_out))
    else $error("first bit is not the most significant bit");
  AST_HOLD_NO_CLK: assert property (st_reg.busy && st_reg.bstb_s[1] && !bclk_rise |=> $stable(st_reg.shift))
    else $error("data shifted without a unit clock edge");
  AST_WORD_LEN: assert property (seq_last_bit |=> !st_reg.busy)
    else $error("word did not end after 24 bits");
  AST_SEL_ADDR: assert property ((seq_load and !st_reg.any_mode) |-> st_reg.mux_s2 == (MUX_DIG_BASE | {2'h0, st_reg.addr}))
    else $error("select mode served a foreign address");
  AST_CLR_ADDR: assert property (wr_go && st_reg.aw_addr == REG_CTRL && st_reg.w_strb == STRB_ALL && st_reg.w_data[CTRL_CLR_ADDR_BIT] |=> st_reg.addr == ADDR_RESET)
    else $error("address clear did not give all ones");
  AST_ADDR_KEEPS_DATA: assert property (wr_go && st_reg.aw_addr == REG_ADDR && (st_reg.busy || !fifo_out_valid) |=> $stable(st_reg.data))
    else $error("address write altered the data");
  AST_SIM_PATTERN: assert property (areq_rise && st_reg.unit_s2 != hw_now |=> asb_ack_out && asb_word_out == unit_pattern($past(st_reg.unit_s2)) && !asb_real_out)
    else $error("wrong simulated pattern");
  AST_SERIAL_NUM: assert property (areq_rise && st_reg.unit_s2 == hw_now && st_reg.amux_s2 == MUX_SERIAL |=> asb_word_out == {3{$past(st_reg.ant_s2)}})
    else $error("serial number readback wrong");
endmodule

//--- tb/bds_fiu_model.sv
/*
  Partner model of the field interface unit and of the antenna side buffer.
  Assumes the bench clock on clk_in; every pin changes just after its rising edge.
*/
`timescale 1ns/1ns
module bds_fiu_model (
  // Bench clock
  input wire logic clk_in,
  // Unit link
  output logic [7:0] mux_out,
  output logic bin_clk_out,
  output logic bin_strobe_out,
  input wire logic bin_data_in,
  input wire logic bin_active_in,
  // Buffer request
  output logic req_out,
  output logic [1:0] unit_out,
  output logic [7:0] bmux_out,
  input wire logic ack_in
);
  initial
  begin
    mux_out = 8'h00;
    bin_clk_out = 1'h0;
    bin_strobe_out = 1'h0;
    req_out = 1'h0;
    unit_out = 2'h0;
    bmux_out = 8'h00;
  end

  // The unit clock runs only inside a strobe frame, 80 ns a period.
  task automatic shift_word(input logic [7:0] m, output logic [23:0] w, output logic ok);
    int n;
    w = 24'h000000;
    @(posedge clk_in);
    mux_out <= m;
    repeat (4) @(posedge clk_in);
    bin_strobe_out <= 1'h1;
    for (n = 0; n < 20 && bin_active_in !== 1'h1; n++)
      @(posedge clk_in);
    ok = (bin_active_in === 1'h1);
    for (n = 0; n < 24 && ok; n++)
    begin
      repeat (5) @(posedge clk_in);
      w = {w[22:0], bin_data_in};
      bin_clk_out <= 1'h1;
      repeat (5) @(posedge clk_in);
      bin_clk_out <= 1'h0;
    end
    bin_strobe_out <= 1'h0;
  endtask

  // Requests are spaced well apart so every rise is seen.
  task automatic ask(input logic [1:0] u, input logic [7:0] m, output logic ok);
    int n;
    @(posedge clk_in);
    unit_out <= u;
    bmux_out <= m;
    req_out <= 1'h1;
    for (n = 0; n < 20 && ack_in !== 1'h1; n++)
      @(posedge clk_in);
    ok = (ack_in === 1'h1);
    req_out <= 1'h0;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

//--- tb/bds_bench_data_source_tb_top.sv
/*
  Self-checking bench: register bus, unit link and port selector.
  Assumes bds_pkg, the design and the partner model are compiled first.
*/
`timescale 1ns/1ns
module bds_bench_data_source_tb_top;
  import bds_pkg::*;
  logic clk_in = 1'h0;
  logic arst_n_in;
  logic [7:0] awaddr, araddr, smux, bmux, ant_id;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, uaddr, bunit, port;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic bclk, bstb, bdata, bact, req, ack, breal, cstb;
  logic [23:0] bword, cmd;
  logic [3:0] wstrb;
  logic [1:0] bs_last;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #4 clk_in = ~clk_in;

  bds_bench_data_source bds_bench_data_source_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .sequence_mux_state_in(smux),
    .fiu_cmd_data_in(cmd), .fiu_cmd_strobe_in(cstb), .fiu_bin_clk_in(bclk),
    .fiu_bin_strobe_in(bstb), .fiu_bin_data_out(bdata), .fiu_bin_active_out(bact),
    .unit_address_switch_in(uaddr), .ant_id_switch_in(ant_id), .asb_req_in(req),
    .asb_unit_in(bunit), .asb_mux_in(bmux), .asb_word_out(bword), .asb_real_out(breal),
    .asb_port_out(port), .asb_ack_out(ack));

  bds_fiu_model fiu (.clk_in(clk_in), .mux_out(smux), .bin_clk_out(bclk),
    .bin_strobe_out(bstb), .bin_data_in(bdata), .bin_active_in(bact), .req_out(req),
    .unit_out(bunit), .bmux_out(bmux), .ack_in(ack));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk_in);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid === 1'h1)
        break;
    end
    bs_last = bresp;
    bready <= 1'h0;
    if (n == 200)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk_in);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
        break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'h0;
    if (n == 200)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  function automatic logic [31:0] exp_asb(input logic [1:0] u, input logic [1:0] hw,
    input logic plain);
    logic [23:0] pats [4];
    pats = '{PAT_UNIT0, PAT_UNIT1, PAT_UNIT2, PAT_UNIT3};
    if (u != hw)
      return {8'h00, pats[u]};
    return plain ? 32'h1000000 : {7'h00, 1'h1, ant_id, ant_id, ant_id};
  endfunction

  initial
  begin
    logic [31:0] d, r, e;
    logic [23:0] w;
    logic [5:0] a;
    logic [1:0] rs, u, pp;
    logic ok;
    int i;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, cmd, cstb} = '0;
    wstrb = STRB_ALL;
    arst_n_in = 1'h0;
    void'($urandom(83524));
    ant_id = 8'($urandom);
    uaddr = 2'($urandom);
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'h1;
    rd(REG_ADDR, r, rs);
    chk(r, {26'h0, ADDR_RESET});
    rd(REG_DATA, r, rs);
    chk(r, {11'h0, DATA_RESET});
    rd(8'h40, r, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    for (i = 0; i < 4; i++)
    begin
      a = (i == 0) ? 6'h00 : 6'($urandom);
      d = (i == 0) ? 32'h0 : {11'h0, 21'($urandom)};
      wr(REG_ADDR, {26'h0, a});
      wr(REG_DATA, d);
      repeat (3) @(posedge clk_in);
      rd(REG_DATA, r, rs);
      chk(r, d);
      fiu.shift_word({2'h2, a}, w, ok);
      chk({31'h0, ok}, 32'h1);
      chk({8'h0, w}, d);
      fiu.shift_word({2'h2, a ^ 6'h01}, w, ok);
      chk({31'h0, ok}, 32'h0);
    end
    wr(REG_CTRL, 32'h1);
    fiu.shift_word({2'h2, a ^ 6'h2A}, w, ok);
    chk({8'h0, w}, d);
    wr(REG_CTRL, 32'h2);
    rd(REG_ADDR, r, rs);
    chk(r, {26'h0, ADDR_RESET});
    chk({30'h0, bs_last}, {30'h0, RESP_OKAY});
    // A write with a partial strobe is answered but must leave the address alone.
    wstrb <= 4'h7;
    wr(REG_ADDR, 32'h15);
    wstrb <= STRB_ALL;
    rd(REG_ADDR, r, rs);
    chk(r, {26'h0, ADDR_RESET});
    rd(REG_DATA, r, rs);
    chk(r, d);
    wr(REG_CTRL, 32'h4);
    rd(REG_DATA, r, rs);
    chk(r, {11'h0, DATA_RESET});
    fiu.shift_word(8'hBF, w, ok);
    chk({8'h0, w}, {11'h0, DATA_RESET});
    rd(REG_STAT, r, rs);
    chk({24'h0, r[7:0]}, 32'hBF);
    for (i = 0; i < 5; i++)
    begin
      u = (i == 4) ? uaddr : 2'(i);
      fiu.ask(u, (i == 4) ? 8'h85 : MUX_SERIAL, ok);
      chk({31'h0, ok}, 32'h1);
      chk({7'h0, breal, bword}, exp_asb(u, uaddr, i == 4));
    end
    pp = 2'($urandom);
    wr(REG_PSEL, {27'h0, 1'h1, pp, uaddr + 2'h1});
    fiu.ask(uaddr + 2'h1, MUX_SERIAL, ok);
    e = exp_asb(uaddr + 2'h1, uaddr + 2'h1, 1'h0);
    chk({port, 5'h0, breal, bword}, {pp, 5'h0, e[24:0]});
    // The command word settles before its strobe rises, as the unit presents it.
    cmd <= 24'($urandom);
    repeat (3) @(posedge clk_in);
    cstb <= 1'h1;
    repeat (4) @(posedge clk_in);
    cstb <= 1'h0;
    rd(REG_CMD, r, rs);
    chk(r, {8'h0, cmd});
    end_sim();
  end
endmodule
